// ---- hw/ssf_fifo.sv ----
`timescale 1ns/1ps
// ***************************************************************
// small staging buffer with valid/ready on both sides
// ***************************************************************
module ssf_fifo
   import ssf_pkg::*;
#(
   parameter int W     = ENTRY_W,
   parameter int DEPTH = STAGE_DEPTH
) (
   input wire logic   clock,
   input wire logic   rst,
   ssf_stream_if.snk  in_s,
   ssf_stream_if.src  out_s
);
   localparam int AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
         $error("ssf_fifo: DEPTH must be a power of two, at least 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           rd;
      logic [AW-1:0]           wr;
      logic [AW:0]             count;
   } ssf_fifo_st_type;

   ssf_fifo_st_type st_r;
   ssf_fifo_st_type st_nxt;
   logic            push;
   logic            pop;

   // honest full and empty straight from the count
   assign in_s.ready  = (st_r.count != (AW+1)'(DEPTH));
   assign out_s.valid = (st_r.count != '0);
   assign out_s.data  = st_r.mem[st_r.rd];
   assign push        = in_s.valid && in_s.ready;
   assign pop         = out_s.valid && out_s.ready;

   // next state
   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.mem[st_r.wr] = in_s.data;
         st_nxt.wr           = st_r.wr + 1'b1;
      end
      if (pop)
         st_nxt.rd = st_r.rd + 1'b1;
      st_nxt.count = st_r.count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clock) begin
      if (rst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

endmodule : ssf_fifo

// ---- hw/ssf_pkg.sv ----
// How it works
// RQ1: storage holds 128 two-byte entries, 256 bytes
// RQ2: entry beyond full sets overflow, data dropped
// RQ3: buffered data is read at 0xFE and 0xFF
// RQ4: address pointer wraps from 0xFF to 0xFE
// RQ5: single or unlimited burst reads accepted
// RQ6: reading 0xFF pops entry, lowers level
// RQ7: burst pops once per completed two-byte entry
// RQ8: reads while empty return zero
// RQ9: interrupt high while any entry is unread
// RQ10: level register at 0xFD, 0 to 128
// RQ11: select bits 1-6 capture channels 0-5
// RQ12: select bit 0 captures one status byte
// RQ13: channel 5 bit ignored under flicker detect
// RQ14: 0xD7 bit 7 captures flicker when enabled
// RQ15: host keeps 0xD7 low bits at 0100001
// RQ16: host should capture status when auto gain
// RQ17: order status, channels 0-5, low byte first
// RQ18: status bytes packed into two-byte entries
package ssf_pkg;

   // ***************************************************************
   // register map
   // ***************************************************************
   localparam logic [7:0] ADDR_FLICKER_CFG = 8'hD7;
   localparam logic [7:0] ADDR_SOURCE_SEL  = 8'hFC;
   localparam logic [7:0] ADDR_FILL_LEVEL  = 8'hFD;
   localparam logic [7:0] ADDR_READ_LOW    = 8'hFE;
   localparam logic [7:0] ADDR_READ_HIGH   = 8'hFF;

   // ***************************************************************
   // reset values and fields
   // ***************************************************************
   localparam logic [7:0] RST_FLICKER_CFG   = 8'h21;
   localparam logic [7:0] RST_SOURCE_SEL    = 8'h00;
   localparam logic [7:0] FLICKER_RSVD_MASK = 8'h7F;
   localparam logic [7:0] SOURCE_SEL_MASK   = 8'h7F;
   localparam int         BIT_CAPTURE_FLK   = 7;
   localparam int         BIT_CAPTURE_CH5   = 6;

   // ***************************************************************
   // sizes and source walk
   // ***************************************************************
   localparam int         STORE_DEPTH = 128;
   localparam int         STAGE_DEPTH = 8;
   localparam int         ENTRY_W     = 16;
   localparam int         NUM_CHAN    = 6;
   localparam logic [2:0] SRC_STATUS  = 3'h0;
   localparam logic [2:0] SRC_FLICKER = 3'h7;

   typedef enum logic {SSF_IDLE, SSF_WALK} ssf_seq_type;

endpackage : ssf_pkg

// ---- hw/ssf_readout.sv ----
`timescale 1ns/1ps
// ***************************************************************
// spectral sample readout buffer
// ***************************************************************
module ssf_readout
   import ssf_pkg::*;
#(
   parameter int DEPTH = STORE_DEPTH,
   parameter int STAGE = STAGE_DEPTH
) (
   input  wire logic                              clock,
   input  wire logic                              rst,
   input  wire logic                              meas_valid,
   input  wire logic [7:0]                        adc_status_byte,
   input  wire logic [NUM_CHAN-1:0][ENTRY_W-1:0]  channel_result,
   input  wire logic [ENTRY_W-1:0]                flicker_data,
   input  wire logic                              flicker_detect_enable,
   input  wire logic                              reg_addr_load,
   input  wire logic [7:0]                        reg_addr_in,
   input  wire logic                              reg_wr,
   input  wire logic [7:0]                        reg_wdata,
   input  wire logic                              reg_rd,
   output logic      [7:0]                        reg_rdata,
   input  wire logic                              overflow_clear,
   output logic                                   overflow_flag,
   output logic                                   capture_busy,
   output logic                                   buffer_data_interrupt,
   output logic      [7:0]                        fill_level_count
);
   localparam int AW = $clog2(DEPTH);

   // level must fit the 8-bit register, pointers must wrap cleanly
   initial begin
      if (DEPTH < 2 || DEPTH > 128 || (DEPTH & (DEPTH - 1)) != 0)
         $error("ssf_readout: DEPTH must be a power of two, 2..128");
      if (STAGE < 2 || (STAGE & (STAGE - 1)) != 0)
         $error("ssf_readout: STAGE must be a power of two, at least 2");
      if (ENTRY_W != 16)
         $error("ssf_readout: entries must be two bytes wide");
      if (NUM_CHAN > 6)
         $error("ssf_readout: source walk has room for six channels");
   end

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      logic [DEPTH-1:0][ENTRY_W-1:0] mem;
      logic [AW-1:0]                 rd_ptr;
      logic [AW-1:0]                 wr_ptr;
      logic [7:0]                    level;
      logic                          overflow;
      logic                          irq;
      logic [7:0]                    addr_ptr;
      logic [7:0]                    rdata;
      logic                          flk_capture;
      logic [6:0]                    source_sel;
      ssf_seq_type                   seq;
      logic [2:0]                    src;
      logic                          phase;
      logic [7:0]                    src_en;
      logic [7:0][ENTRY_W-1:0]       sample;
      logic                          have_low;
      logic [7:0]                    low_byte;
   } ssf_st_type;

   ssf_st_type st_r;
   ssf_st_type st_nxt;

   ssf_stream_if #(.W(ENTRY_W)) pack_s ();
   ssf_stream_if #(.W(ENTRY_W)) store_s ();

   // ***************************************************************
   // staging buffer between packer and storage
   // ***************************************************************
   ssf_fifo #(
      .W     (ENTRY_W),
      .DEPTH (STAGE)
   ) u_stage (
      .clock (clock),
      .rst   (rst),
      .in_s  (pack_s.snk),
      .out_s (store_s.src)
   );

   // ***************************************************************
   // combinational helpers
   // ***************************************************************
   logic       data_rd;
   logic       full;
   logic       pop;
   logic       write;
   logic       emit;
   logic [7:0] emit_byte;
   logic       two_byte;
   logic       stall;
   logic [7:0] en_now;
   logic       empty;
   logic       drop;
   logic       at_low;
   logic       at_high;
   logic       walk_last;
   logic       first_half;
   logic [7:0] flk_cfg_view;
   logic [ENTRY_W-1:0]            head;
   logic [ENTRY_W-1:0]            src_word;
   wire  logic [7:0][ENTRY_W-1:0] fresh;

   // ***************************************************************
   // window decode and head of storage
   // ***************************************************************
   // pointer parked on one of the two data bytes
   assign at_low  = (st_r.addr_ptr == ADDR_READ_LOW);
   assign at_high = (st_r.addr_ptr == ADDR_READ_HIGH);
   // empty store reads zero, never a stale head
   assign empty   = (st_r.level == 8'h00);
   assign head    = st_r.mem[st_r.rd_ptr];
   // reserved low bits are fixed, only the capture bit moves
   assign flk_cfg_view = {st_r.flk_capture, 7'h00}
                         | (RST_FLICKER_CFG & FLICKER_RSVD_MASK);

   // ***************************************************************
   // fresh sample set, one slot per source
   // ***************************************************************
   // slots filled per channel; the walk copies them at meas_valid
   assign fresh[SRC_STATUS]  = {8'h00, adc_status_byte};
   assign fresh[SRC_FLICKER] = flicker_data;
   for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
      assign fresh[g+1] = channel_result[g];
   end

   // ***************************************************************
   // walk helpers
   // ***************************************************************
   // word of the source under the walk, and its position
   assign src_word   = st_r.sample[st_r.src];
   assign walk_last  = (st_r.src == SRC_FLICKER);
   // low half of a two-byte source: stay on it one more cycle
   assign first_half = emit && two_byte && !st_r.phase;

   // ***************************************************************
   // storage handshake and pops
   // ***************************************************************
   // a host read of the window holds storage writes off for a cycle
   assign data_rd = reg_rd && (at_low || at_high);
   assign full    = (st_r.level == 8'(DEPTH));
   // pop on the high byte, one pop per two-byte entry in any burst
   assign pop     = reg_rd && at_high && !empty;          // see RQ6 RQ7
   assign store_s.ready = !data_rd;
   assign write   = store_s.valid && store_s.ready && !full;
   // an entry meeting a full store is lost, not overwritten
   assign drop    = store_s.valid && store_s.ready && full; // see RQ2

   // ***************************************************************
   // capture source enables
   // ***************************************************************
   // sources chosen at the start of each measurement
   always_comb begin
      en_now    = {1'b0, st_r.source_sel};                 // see RQ11 RQ12
      if (flicker_detect_enable)
         en_now[BIT_CAPTURE_CH5] = 1'b0;                   // see RQ13
      en_now[SRC_FLICKER] = st_r.flk_capture
                            && flicker_detect_enable;      // see RQ14
   end

   // byte offered by the walk this cycle, low byte first
   assign two_byte  = (st_r.src != SRC_STATUS);            // see RQ12
   assign emit      = (st_r.seq == SSF_WALK) && st_r.src_en[st_r.src];
   assign emit_byte = st_r.phase ? src_word[15:8]
                                 : src_word[7:0];          // see RQ17
   // a second byte completes an entry; status bytes pair across
   assign pack_s.valid = emit && st_r.have_low;            // see RQ18
   assign pack_s.data  = {emit_byte, st_r.low_byte};
   assign stall        = pack_s.valid && !pack_s.ready;

   // ***************************************************************
   // pointer stepping
   // ***************************************************************
   // address pointer steps by one but folds the data window
   function automatic logic [7:0] ssf_step(input logic [7:0] a);
      ssf_step = (a == ADDR_READ_HIGH) ? ADDR_READ_LOW     // see RQ4
                                       : 8'(a + 8'h01);
   endfunction : ssf_step

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      st_nxt = st_r;

      // capture walk: status, channels 0 to 5, then flicker
      unique case (st_r.seq)
         SSF_IDLE: begin
            if (meas_valid) begin
               st_nxt.seq       = SSF_WALK;
               st_nxt.src       = SRC_STATUS;
               st_nxt.phase     = 1'b0;
               st_nxt.src_en    = en_now;
               st_nxt.sample    = fresh;
            end
         end
         SSF_WALK: begin
            if (!stall) begin
               if (emit) begin
                  st_nxt.have_low = !st_r.have_low;
                  if (!st_r.have_low)
                     st_nxt.low_byte = emit_byte;
               end
               if (first_half) begin
                  st_nxt.phase = 1'b1;
               end else begin
                  st_nxt.phase = 1'b0;
                  st_nxt.src   = st_r.src + 3'h1;
                  if (walk_last)
                     st_nxt.seq = SSF_IDLE;
               end
            end
         end
      endcase

      // storage write; a full store drops the entry instead
      if (write) begin
         st_nxt.mem[st_r.wr_ptr] = store_s.data;           // see RQ1
         st_nxt.wr_ptr           = st_r.wr_ptr + 1'b1;
      end
      if (pop)
         st_nxt.rd_ptr = st_r.rd_ptr + 1'b1;
      st_nxt.level = st_r.level + 8'(write) - 8'(pop);     // see RQ10

      // overflow is sticky; a new drop beats a clear
      if (overflow_clear)
         st_nxt.overflow = 1'b0;
      if (drop)
         st_nxt.overflow = 1'b1;                           // see RQ2

      st_nxt.irq = (st_nxt.level != 8'h00);                // see RQ9

      // register access through the auto-stepping pointer
      if (reg_addr_load)
         st_nxt.addr_ptr = reg_addr_in;
      if (reg_wr) begin
         unique case (st_r.addr_ptr)
            ADDR_SOURCE_SEL:
               st_nxt.source_sel = reg_wdata[6:0];
            ADDR_FLICKER_CFG:
               st_nxt.flk_capture = reg_wdata[BIT_CAPTURE_FLK];
            default: ;
         endcase
         st_nxt.addr_ptr = ssf_step(st_r.addr_ptr);
      end
      if (reg_rd) begin
         unique case (st_r.addr_ptr)
            ADDR_FLICKER_CFG:
               st_nxt.rdata = flk_cfg_view;
            ADDR_SOURCE_SEL:
               st_nxt.rdata = {1'b0, st_r.source_sel};
            ADDR_FILL_LEVEL:
               st_nxt.rdata = st_r.level;
            // empty buffer reads as zero
            ADDR_READ_LOW:
               st_nxt.rdata = empty ? 8'h00 : head[7:0];   // see RQ3 RQ8
            ADDR_READ_HIGH:
               st_nxt.rdata = empty ? 8'h00 : head[15:8];  // see RQ3 RQ8
            default:
               st_nxt.rdata = 8'h00;
         endcase
         // no burst length limit: the pointer just keeps folding
         st_nxt.addr_ptr = ssf_step(st_r.addr_ptr);        // see RQ5
      end
   end

   // ***************************************************************
   // register the state
   // ***************************************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         st_r             <= '0;
         st_r.seq         <= SSF_IDLE;
         st_r.source_sel  <= RST_SOURCE_SEL[6:0];
         st_r.flk_capture <= RST_FLICKER_CFG[BIT_CAPTURE_FLK];
      end else begin
         st_r <= st_nxt;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   // every output comes straight from a flop, so none can glitch
   assign reg_rdata             = st_r.rdata;
   assign overflow_flag         = st_r.overflow;
   assign capture_busy          = (st_r.seq == SSF_WALK);
   assign buffer_data_interrupt = st_r.irq;
   assign fill_level_count      = st_r.level;

endmodule : ssf_readout

// ---- hw/ssf_stream_if.sv ----
`timescale 1ns/1ps
// entry stream between capture, staging buffer and storage
interface ssf_stream_if #(parameter int W = 16);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : ssf_stream_if

// ---- tb/ssf_host_model.sv ----
`timescale 1ns/1ps
// ********************
// host on the register port
// ********************
module ssf_host_model
   import ssf_pkg::*;
(
   input  wire logic       clock,
   output logic            reg_addr_load,
   output logic [7:0]      reg_addr_in,
   output logic            reg_wr,
   output logic [7:0]      reg_wdata,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata
);
   logic [7:0] got [$];

   // idle bus; auto gain never on here, status capture optional
   initial begin
      reg_addr_load = 1'b0;
      reg_addr_in   = 8'h00;
      reg_wr        = 1'b0;
      reg_wdata     = 8'h00;
      reg_rd        = 1'b0;
   end

   // pointer load, then one write; released lines go to the inverse
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      reg_addr_load = 1'b1;
      reg_addr_in   = a;
      @(negedge clock);
      reg_addr_load = 1'b0;
      reg_addr_in   = ~a;
      reg_wr        = 1'b1;
      reg_wdata     = d;
      if (a == ADDR_FLICKER_CFG) begin
         reg_wdata = (d & ~FLICKER_RSVD_MASK) | RST_FLICKER_CFG;
      end
      @(negedge clock);
      reg_wr    = 1'b0;
      reg_wdata = ~reg_wdata;
   endtask : wr

   // read strobe held n edges, one byte taken per edge
   task automatic burst(input logic [7:0] a, input int n);
      got.delete();
      @(negedge clock);
      reg_addr_load = 1'b1;
      reg_addr_in   = a;
      @(negedge clock);
      reg_addr_load = 1'b0;
      reg_addr_in   = ~a;
      reg_rd        = 1'b1;
      repeat (n) begin
         @(negedge clock);
         got.push_back(reg_rdata);
      end
      reg_rd = 1'b0;
   endtask : burst
endmodule : ssf_host_model

// ---- tb/ssf_readout_chk.sv ----
`timescale 1ns/1ps
// ********************
// port checker
// ********************
module ssf_readout_chk
   import ssf_pkg::*;
#(
   parameter int DEPTH = STORE_DEPTH,
   parameter int STAGE = STAGE_DEPTH
) (
   input wire logic       clock,
   input wire logic       rst,
   input wire logic       meas_valid,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       overflow_clear,
   input wire logic       overflow_flag,
   input wire logic       capture_busy,
   input wire logic       buffer_data_interrupt,
   input wire logic [7:0] fill_level_count
);
   logic [3:0] idle_r;
   logic [3:0] idle_nxt;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   // cycles since the walk ended, saturating so it never wraps
   always_comb begin
      idle_nxt = (idle_r == 4'hF) ? idle_r : idle_r + 4'h1;
      if (capture_busy) begin
         idle_nxt = 4'h0;
      end
   end
   always_ff @(posedge clock) begin
      idle_r <= rst ? 4'hF : idle_nxt;
   end

   sequence walk_s;
      capture_busy [*7];
   endsequence
   sequence walk_end_s;
      ##[7:60] !capture_busy;
   endsequence

   busy_start_a: assert property (meas_valid && !capture_busy |=> walk_s)
      else $error("walk too short");
   walk_end_a: assert property ($rose(capture_busy) |-> walk_end_s)
      else $error("walk never ends");
   irq_set_a: assert property (fill_level_count != 8'h00 |-> ##[0:1] buffer_data_interrupt)
      else $error("interrupt missing");
   irq_clr_a: assert property (fill_level_count == 8'h00 |-> ##[0:1] !buffer_data_interrupt)
      else $error("interrupt while empty");
   level_max_a: assert property (fill_level_count <= DEPTH)
      else $error("level above depth");
   level_step_a: assert property ($changed(fill_level_count) |->
      (fill_level_count - $past(fill_level_count)) inside {8'h01, 8'hFF})
      else $error("level jumped");
   pop_rd_a: assert property (fill_level_count < $past(fill_level_count) |-> $past(reg_rd))
      else $error("pop without read");
   fill_cap_a: assert property (fill_level_count > $past(fill_level_count) |-> idle_r < 4'h8)
      else $error("entry without capture");
   ovf_set_a: assert property ($rose(overflow_flag) |-> fill_level_count == DEPTH)
      else $error("overflow below full");
   ovf_hold_a: assert property (overflow_flag && !overflow_clear |=> overflow_flag)
      else $error("overflow lost");
   rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved");
endmodule : ssf_readout_chk

bind ssf_readout ssf_readout_chk #(.DEPTH(DEPTH), .STAGE(STAGE)) chk_inst (
   .clock(clock), .rst(rst), .meas_valid(meas_valid), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .overflow_clear(overflow_clear),
   .overflow_flag(overflow_flag), .capture_busy(capture_busy),
   .buffer_data_interrupt(buffer_data_interrupt),
   .fill_level_count(fill_level_count)
);

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
// ********************
// readout bench with entry model
// ********************
module testbench
   import ssf_pkg::*;
;
   logic                             clock, rst, mv, fde, oclr;
   logic                             ld, wr, rd, ovf, busy, irq;
   logic [7:0]                       ast, ain, wd, rdata, lvl;
   logic [NUM_CHAN-1:0][ENTRY_W-1:0] chr;
   logic [ENTRY_W-1:0]               flk;
   logic [15:0]                      eq [$];
   logic [7:0]                       pend, sel_m, cfg_m;
   bit                               has_pend, m_ovf;
   int                               error_cnt, compares, k;

   ssf_readout ssf_readout_inst (
      .clock(clock), .rst(rst), .meas_valid(mv), .adc_status_byte(ast),
      .channel_result(chr), .flicker_data(flk), .flicker_detect_enable(fde),
      .reg_addr_load(ld), .reg_addr_in(ain), .reg_wr(wr), .reg_wdata(wd),
      .reg_rd(rd), .reg_rdata(rdata), .overflow_clear(oclr),
      .overflow_flag(ovf), .capture_busy(busy),
      .buffer_data_interrupt(irq), .fill_level_count(lvl)
   );
   ssf_host_model host_inst (
      .clock(clock), .reg_addr_load(ld), .reg_addr_in(ain), .reg_wr(wr),
      .reg_wdata(wd), .reg_rd(rd), .reg_rdata(rdata)
   );

   // 40 MHz clock
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // hang guard, well beyond the few thousand cycles needed
   initial begin
      #(25 * 40000);
      error_cnt++;
      close_out();
   end

   task automatic chk(input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : chk

   task automatic close_out();
      $display("compares=%0d error_cnt=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out

   // odd bytes wait for a partner, even across measurements
   task automatic push_b(input logic [7:0] b);
      has_pend = !has_pend;
      if (has_pend) begin
         pend = b;
      end else if (eq.size() < STORE_DEPTH) begin
         eq.push_back({b, pend});
      end else begin
         m_ovf = 1'b1;
      end
   endtask : push_b

   task automatic measure(input bit fd);
      int i;
      @(negedge clock);
      ast = 8'($urandom);
      flk = 16'($urandom);
      for (i = 0; i < NUM_CHAN; i++) begin
         chr[i] = 16'($urandom);
      end
      fde = fd;
      mv  = 1'b1;
      @(negedge clock);
      mv = 1'b0;
      if (sel_m[0]) begin
         push_b(ast);
      end
      for (i = 0; i < NUM_CHAN; i++) begin
         if (sel_m[i+1] && !(i == 5 && fd)) begin
            push_b(chr[i][7:0]);
            push_b(chr[i][15:8]);
         end
      end
      if (cfg_m[7] && fd) begin
         push_b(flk[7:0]);
         push_b(flk[15:8]);
      end
      for (i = 0; i < 60 && (busy || lvl !== 8'(eq.size())); i++) begin
         @(negedge clock);
      end
      chk(8'(eq.size()), lvl);
      chk({7'h00, eq.size() != 0}, {7'h00, irq});
      chk({7'h00, m_ovf}, {7'h00, ovf});
   endtask : measure

   // n bytes from a data address; empty store reads as zero
   task automatic drain(input logic [7:0] a, input int n);
      int i;
      logic [15:0] e;
      host_inst.burst(a, n);
      for (i = 0; i < n; i++) begin
         e = (eq.size() != 0) ? eq[0] : 16'h0000;
         if ((i + int'(a[0])) % 2 == 0) begin
            chk(e[7:0], host_inst.got[i]);
         end else begin
            chk(e[15:8], host_inst.got[i]);
            if (eq.size() != 0) begin
               void'(eq.pop_front());
            end
         end
      end
      chk(8'(eq.size()), lvl);
   endtask : drain

   task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
      host_inst.burst(a, 1);
      chk(exp, host_inst.got[0]);
   endtask : rreg

   // main sequence
   initial begin
      rst = 1'b1;
      mv = 1'b0;
      fde = 1'b0;
      oclr = 1'b0;
      ast = 8'h00;
      chr = '0;
      flk = 16'h0000;
      sel_m = RST_SOURCE_SEL;
      cfg_m = RST_FLICKER_CFG;
      void'($urandom(32'hEBBB9334));
      repeat (20) @(negedge clock);
      rst = 1'b0;
      rreg(ADDR_FLICKER_CFG, RST_FLICKER_CFG);
      rreg(ADDR_SOURCE_SEL, RST_SOURCE_SEL);
      rreg(ADDR_READ_HIGH, 8'h00);
      rreg(8'h10, 8'h00); // unmapped
      host_inst.wr(ADDR_FILL_LEVEL, 8'h5A);
      rreg(ADDR_FILL_LEVEL, 8'h00);
      host_inst.wr(ADDR_FLICKER_CFG, 8'hFF);
      cfg_m = 8'hA1;
      rreg(ADDR_FLICKER_CFG, cfg_m);
      for (k = 0; k < 12; k++) begin
         sel_m = (k == 0) ? 8'h7F : 8'($urandom) & SOURCE_SEL_MASK;
         host_inst.wr(ADDR_SOURCE_SEL, sel_m | 8'h80);
         rreg(ADDR_SOURCE_SEL, sel_m);
         measure(k[0]);
         if (k % 3 == 2) begin
            drain(k[2] ? ADDR_READ_HIGH : ADDR_READ_LOW, 2 * eq.size() + 3);
         end
      end
      drain(ADDR_READ_LOW, 2 * eq.size());
      sel_m = 8'h02;
      host_inst.wr(ADDR_SOURCE_SEL, sel_m);
      for (k = 0; k <= STORE_DEPTH; k++) begin
         measure(1'b0);
      end
      drain(ADDR_READ_LOW, 100);
      @(negedge clock);
      oclr = 1'b1;
      @(negedge clock);
      oclr = 1'b0;
      m_ovf = 1'b0;
      chk(8'h00, {7'h00, ovf});
      drain(ADDR_READ_LOW, 2 * eq.size() + 4);
      close_out();
   end
endmodule : testbench
